/* File: rtl/i2css_pkg.sv */
package i2css_pkg;
   // ==========================================
   // register offsets
   localparam logic [2:0] REG_SERIAL_CTRL0 = 3'h0;
   localparam logic [2:0] REG_STATUS_CTRL  = 3'h1;
   localparam logic [2:0] REG_DATA         = 3'h2;
   localparam logic [2:0] REG_OWN_ADDR     = 3'h3;
   localparam logic [2:0] REG_TIMEOUT      = 3'h4;

   // ==========================================
   // serial_ctrl0 fields
   localparam int unsigned CTRL0_MODE_LSB  = 5;
   localparam int unsigned CTRL0_UART_BIT  = 4;
   localparam int unsigned CTRL0_EN_BIT    = 1;
   localparam logic [2:0]  MODE_I2C_SLAVE  = 3'h6;
   localparam logic [7:0]  CTRL0_RESET     = 8'hE0;

   // ==========================================
   // i2c_status_control fields
   localparam int unsigned ST_XFER_DONE   = 7;
   localparam int unsigned ST_ADDR_MATCH  = 6;
   localparam int unsigned ST_BUS_BUSY    = 5;
   localparam int unsigned ST_DIR_TX      = 4;
   localparam int unsigned ST_ACK_TO_SEND = 3;
   localparam int unsigned ST_MASTER_RW   = 2;
   localparam int unsigned ST_WAKE_EN     = 1;
   localparam int unsigned ST_ACK_RX_N    = 0;
   localparam logic [7:0]  STATUS_RESET   = 8'h81;

   // ==========================================
   // time-out register fields
   localparam int unsigned TO_EN_BIT      = 7;
   localparam int unsigned TO_FLAG_BIT    = 6;
   localparam logic [7:0]  TO_RESET       = 8'h00;
   localparam logic [7:0]  OWN_ADDR_RESET = 8'h00;

   // ==========================================
   // timing
   localparam int unsigned SYS_CLK_NS     = 10;
   localparam int unsigned TO_UNIT_NS     = 976562;
   localparam int unsigned TO_UNIT_CYC    = TO_UNIT_NS / SYS_CLK_NS;
   localparam logic [3:0]  BITS_LAST      = 4'h7;
   localparam logic [3:0]  BITS_BYTE      = 4'h8;
   localparam logic [3:0]  BITS_ACK       = 4'h9;

   // ==========================================
   // protocol states
   typedef enum logic [7:0] {
      ST_IDLE      = 8'h01,
      ST_ADDR      = 8'h02,
      ST_ACK       = 8'h04,
      ST_STRETCH   = 8'h08,
      ST_RX        = 8'h10,
      ST_TX        = 8'h20,
      ST_TX_ACK    = 8'h40,
      ST_WAIT_STOP = 8'h80
   } i2css_state_t;
endpackage

/* File: rtl/i2css_slave.sv */
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - byte done sets done flag, interrupts
// - matched flag follows address compare result
// - start sets busy, stop clears busy
// - direction bit picks receive or transmit
// - ninth clock drives ack_to_send value
// - eighth address bit stored as master_rw
// - match with wake enable wakes device
// - transmit ninth clock samples master ack
// - master nack releases sda for stop
// - first seven bits msb-first are address
// - address match sets flag and interrupts
// - matched address acknowledged low on ninth
// - start is sda fall while scl high
// - hold scl until data written/read
// - one interrupt from three sources
// - active only uart off, mode 110, enabled
// - bytes eight bits msb first, low ack
// - time-out stops, flags, interrupts, resets status
module i2css_slave #(
   parameter logic [31:0] P_TO_UNIT_CYC = i2css_pkg::TO_UNIT_CYC
) (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_sys_rst,
   // register port
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rdata,
   // bus pins
   input  wire logic       i_scl,
   output logic            o_scl,
   output logic            o_scl_oe_n,
   input  wire logic       i_sda,
   output logic            o_sda,
   output logic            o_sda_oe_n,
   // system events
   output logic            o_irq,
   output logic            o_wake
);
   // ==========================================
   // pin synchronisers
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_s3_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_s3_q <= 1'b1;
      end
      else
      begin
         scl_s1_q <= i_scl;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= i_sda;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise  = scl_s2_q & ~scl_s3_q;
   assign scl_fall  = ~scl_s2_q & scl_s3_q;
   assign start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
   assign stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

   // ==========================================
   // software registers
   logic [7:0] ctrl0_q, own_addr_q, data_q;
   logic       dir_tx_q, ack_to_send_q, wake_en_q;
   logic       to_en_q, to_flag_q, to_evt_q;
   logic [5:0] to_period_q;
   logic       en;
   assign en = ~ctrl0_q[i2css_pkg::CTRL0_UART_BIT] & ctrl0_q[i2css_pkg::CTRL0_EN_BIT]
             & (ctrl0_q[i2css_pkg::CTRL0_MODE_LSB +: 3] == i2css_pkg::MODE_I2C_SLAVE);

   logic wr_ctrl0, wr_stat, wr_data, wr_own, wr_to, rd_data;
   assign wr_ctrl0 = i_wr & (i_addr == i2css_pkg::REG_SERIAL_CTRL0);
   assign wr_stat  = i_wr & (i_addr == i2css_pkg::REG_STATUS_CTRL);
   assign wr_data  = i_wr & (i_addr == i2css_pkg::REG_DATA);
   assign wr_own   = i_wr & (i_addr == i2css_pkg::REG_OWN_ADDR);
   assign wr_to    = i_wr & (i_addr == i2css_pkg::REG_TIMEOUT);
   assign rd_data  = i_rd & (i_addr == i2css_pkg::REG_DATA);

   // ==========================================
   // protocol state
   i2css_pkg::i2css_state_t state_q;
   logic [3:0] bitcnt_q;
   logic [7:0] shift_q;
   logic [7:0] shin;
   logic       nack_q;
   logic       xfer_done_q, addr_matched_q, bus_busy_q, master_rw_q, ack_received_n_q;
   logic       go, svc, match_evt, rxdone_evt, txdone_evt;

   assign shin       = {shift_q[6:0], sda_s2_q};
   assign go         = en & ~to_evt_q & ~start_det & ~stop_det;
   assign match_evt  = go & (state_q == i2css_pkg::ST_ADDR) & scl_rise & (bitcnt_q == i2css_pkg::BITS_LAST)
                     & (shin[7:1] == own_addr_q[7:1]);
   assign rxdone_evt = go & (state_q == i2css_pkg::ST_RX) & scl_rise & (bitcnt_q == i2css_pkg::BITS_LAST);
   assign txdone_evt = go & (state_q == i2css_pkg::ST_TX) & scl_fall & (bitcnt_q == i2css_pkg::BITS_BYTE);
   // tx is serviced by a data write, rx by a dummy data read
   assign svc = (state_q == i2css_pkg::ST_STRETCH) & (dir_tx_q ? wr_data : rd_data);

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q          <= i2css_pkg::ST_IDLE;
         bitcnt_q         <= 4'h0;
         shift_q          <= 8'h00;
         nack_q           <= 1'b0;
         o_sda_oe_n       <= 1'b1;
         o_scl_oe_n       <= 1'b1;
         xfer_done_q      <= 1'b1;
         addr_matched_q   <= 1'b0;
         bus_busy_q       <= 1'b0;
         master_rw_q      <= 1'b0;
         ack_received_n_q <= 1'b1;
      end
      else if (!en || to_evt_q)
      begin
         // disabled or timed out: flags back to power-on values
         state_q          <= i2css_pkg::ST_IDLE;
         o_sda_oe_n       <= 1'b1;
         o_scl_oe_n       <= 1'b1;
         xfer_done_q      <= 1'b1;
         addr_matched_q   <= 1'b0;
         bus_busy_q       <= 1'b0;
         master_rw_q      <= 1'b0;
         ack_received_n_q <= 1'b1;
      end
      else if (start_det)
      begin
         // repeated start also lands here; we never make one ourselves
         bus_busy_q     <= 1'b1;
         addr_matched_q <= 1'b0;
         state_q        <= i2css_pkg::ST_ADDR;
         bitcnt_q       <= 4'h0;
         o_sda_oe_n     <= 1'b1;
         o_scl_oe_n     <= 1'b1;
      end
      else if (stop_det)
      begin
         bus_busy_q <= 1'b0;
         state_q    <= i2css_pkg::ST_IDLE;
         o_sda_oe_n <= 1'b1;
         o_scl_oe_n <= 1'b1;
      end
      else
      begin
         case (state_q)
            i2css_pkg::ST_ADDR:
               if (scl_rise)
               begin
                  shift_q  <= shin;
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (bitcnt_q == i2css_pkg::BITS_LAST)
                  begin
                     if (match_evt)
                     begin
                        addr_matched_q <= 1'b1;
                        master_rw_q    <= sda_s2_q;
                        nack_q         <= 1'b0;
                        state_q        <= i2css_pkg::ST_ACK;
                     end
                     else
                     begin
                        addr_matched_q <= 1'b0;
                        state_q        <= i2css_pkg::ST_WAIT_STOP;
                     end
                  end
               end
            i2css_pkg::ST_ACK:
               if (scl_fall)
               begin
                  if (bitcnt_q == i2css_pkg::BITS_BYTE)
                  begin
                     o_sda_oe_n <= nack_q;
                     bitcnt_q   <= i2css_pkg::BITS_ACK;
                  end
                  else
                  begin
                     o_sda_oe_n <= 1'b1;
                     o_scl_oe_n <= 1'b0;
                     state_q    <= i2css_pkg::ST_STRETCH;
                  end
               end
            i2css_pkg::ST_STRETCH:
               if (svc)
               begin
                  o_scl_oe_n  <= 1'b1;
                  xfer_done_q <= 1'b0;
                  if (dir_tx_q)
                  begin
                     // first bit goes out in the same cycle that scl is let go
                     shift_q    <= i_wdata;
                     o_sda_oe_n <= i_wdata[7];
                     bitcnt_q   <= 4'h1;
                     state_q    <= i2css_pkg::ST_TX;
                  end
                  else
                  begin
                     bitcnt_q <= 4'h0;
                     state_q  <= i2css_pkg::ST_RX;
                  end
               end
            i2css_pkg::ST_RX:
               if (scl_rise)
               begin
                  shift_q  <= shin;
                  bitcnt_q <= bitcnt_q + 4'h1;
                  if (rxdone_evt)
                  begin
                     xfer_done_q <= 1'b1;
                     nack_q      <= ack_to_send_q;
                     state_q     <= i2css_pkg::ST_ACK;
                  end
               end
            i2css_pkg::ST_TX:
               if (scl_fall)
               begin
                  if (txdone_evt)
                  begin
                     xfer_done_q <= 1'b1;
                     o_sda_oe_n  <= 1'b1;
                     state_q     <= i2css_pkg::ST_TX_ACK;
                  end
                  else
                  begin
                     o_sda_oe_n <= shift_q[6];
                     shift_q    <= {shift_q[6:0], 1'b0};
                     bitcnt_q   <= bitcnt_q + 4'h1;
                  end
               end
            i2css_pkg::ST_TX_ACK:
               if (scl_rise)
               begin
                  ack_received_n_q <= sda_s2_q;
                  bitcnt_q         <= i2css_pkg::BITS_ACK;
                  // nack: leave sda released and wait for the master's stop
                  state_q <= sda_s2_q ? i2css_pkg::ST_WAIT_STOP : i2css_pkg::ST_ACK;
               end
            i2css_pkg::ST_IDLE, i2css_pkg::ST_WAIT_STOP:
               o_sda_oe_n <= 1'b1;
            default:
               state_q <= i2css_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // software registers and data buffer
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ctrl0_q       <= i2css_pkg::CTRL0_RESET;
         own_addr_q    <= i2css_pkg::OWN_ADDR_RESET;
         data_q        <= 8'h00;
         dir_tx_q      <= 1'b0;
         ack_to_send_q <= 1'b0;
         wake_en_q     <= 1'b0;
         to_en_q       <= 1'b0;
         to_flag_q     <= 1'b0;
         to_period_q   <= 6'h00;
      end
      else
      begin
         if (wr_ctrl0)
            ctrl0_q <= i_wdata;
         if (wr_own)
            own_addr_q <= i_wdata;
         if (rxdone_evt)
            data_q <= shin;
         else if (wr_data)
            data_q <= i_wdata;
         // status writable bits return to power-on values on time-out
         if (to_evt_q)
         begin
            dir_tx_q      <= i2css_pkg::STATUS_RESET[i2css_pkg::ST_DIR_TX];
            ack_to_send_q <= i2css_pkg::STATUS_RESET[i2css_pkg::ST_ACK_TO_SEND];
            wake_en_q     <= i2css_pkg::STATUS_RESET[i2css_pkg::ST_WAKE_EN];
         end
         else if (wr_stat)
         begin
            dir_tx_q      <= i_wdata[i2css_pkg::ST_DIR_TX];
            ack_to_send_q <= i_wdata[i2css_pkg::ST_ACK_TO_SEND];
            wake_en_q     <= i_wdata[i2css_pkg::ST_WAKE_EN];
         end
         if (wr_to)
            to_period_q <= i_wdata[5:0];
         // hardware set of the flag wins over a clearing write
         if (to_evt_q)
         begin
            to_en_q   <= 1'b0;
            to_flag_q <= 1'b1;
         end
         else if (wr_to)
         begin
            to_en_q   <= i_wdata[i2css_pkg::TO_EN_BIT];
            to_flag_q <= i_wdata[i2css_pkg::TO_FLAG_BIT];
         end
      end
   end

   // ==========================================
   // time-out counter
   logic [31:0] pre_q;
   logic [5:0]  unit_q;
   logic        to_run_q;

   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         pre_q    <= 32'h0;
         unit_q   <= 6'h00;
         to_run_q <= 1'b0;
         to_evt_q <= 1'b0;
      end
      else
      begin
         to_evt_q <= 1'b0;
         if (!en || stop_det || to_evt_q)
            to_run_q <= 1'b0;
         else if (match_evt)
            to_run_q <= 1'b1;
         if (scl_fall || !to_run_q || !to_en_q)
         begin
            pre_q  <= 32'h0;
            unit_q <= 6'h00;
         end
         else if (pre_q == P_TO_UNIT_CYC - 32'h1)
         begin
            pre_q  <= 32'h0;
            unit_q <= unit_q + 6'h01;
            if (unit_q == to_period_q)
               to_evt_q <= 1'b1;
         end
         else
            pre_q <= pre_q + 32'h1;
      end
   end

   // ==========================================
   // read port and event outputs
   always_ff @(posedge i_sys_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rdata <= 8'h00;
         o_irq   <= 1'b0;
         o_wake  <= 1'b0;
         o_scl   <= 1'b0;
         o_sda   <= 1'b0;
      end
      else
      begin
         o_scl   <= 1'b0;
         o_sda   <= 1'b0;
         o_irq   <= match_evt | rxdone_evt | txdone_evt | to_evt_q;
         o_wake  <= match_evt & wake_en_q;
         o_rdata <= 8'h00;
         if (i_rd)
         begin
            case (i_addr)
               i2css_pkg::REG_SERIAL_CTRL0: o_rdata <= ctrl0_q;
               i2css_pkg::REG_STATUS_CTRL:  o_rdata <= {xfer_done_q, addr_matched_q, bus_busy_q, dir_tx_q,
                                                       ack_to_send_q, master_rw_q, wake_en_q, ack_received_n_q};
               i2css_pkg::REG_DATA:         o_rdata <= data_q;
               i2css_pkg::REG_OWN_ADDR:     o_rdata <= own_addr_q;
               i2css_pkg::REG_TIMEOUT:      o_rdata <= {to_en_q, to_flag_q, to_period_q};
               default:                     o_rdata <= 8'h00;
            endcase
         end
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_addr_last;
      go && state_q == i2css_pkg::ST_ADDR && scl_rise && bitcnt_q == i2css_pkg::BITS_LAST;
   endsequence
   sequence s_ack_drive;
      go && state_q == i2css_pkg::ST_ACK && scl_fall && bitcnt_q == i2css_pkg::BITS_BYTE;
   endsequence
   sequence s_nack_seen;
      go && state_q == i2css_pkg::ST_TX_ACK && scl_rise && sda_s2_q;
   endsequence

   AST_BUSY_SET: assert property (en && !to_evt_q && start_det |=> bus_busy_q)
      else $error("busy not set after start");
   AST_BUSY_CLR: assert property (en && !to_evt_q && !start_det && stop_det |=> !bus_busy_q)
      else $error("busy not cleared after stop");
   AST_MATCH: assert property (s_addr_last and match_evt |=> addr_matched_q && o_irq ##1 !o_irq)
      else $error("address match not flagged");
   AST_NOMATCH: assert property (s_addr_last and !match_evt |=> !addr_matched_q && !o_irq)
      else $error("mismatch flagged");
   AST_RW: assert property (match_evt |=> master_rw_q == $past(sda_s2_q))
      else $error("read/write bit not stored");
   AST_ACK: assert property (s_ack_drive |=> o_sda_oe_n == $past(nack_q))
      else $error("ack level wrong");
   AST_XFER: assert property (rxdone_evt |=> xfer_done_q && o_irq && data_q == $past(shin))
      else $error("byte completion not flagged");
   AST_STRETCH: assert property (go && state_q == i2css_pkg::ST_STRETCH && !svc |=> !o_scl_oe_n)
      else $error("scl not held");
   AST_RELEASE: assert property (go && svc |=> o_scl_oe_n && !xfer_done_q)
      else $error("scl not released");
   AST_NACK: assert property (s_nack_seen |=> ack_received_n_q && o_sda_oe_n ##1 o_sda_oe_n)
      else $error("sda not released on nack");
   AST_TIMEOUT: assert property (to_evt_q |=> to_flag_q && !to_en_q && o_irq && xfer_done_q)
      else $error("time-out handling wrong");
   AST_WAKE: assert property (match_evt && wake_en_q |=> o_wake)
      else $error("wake missing");
   AST_MODE: assert property (!en |=> state_q == i2css_pkg::ST_IDLE && o_scl_oe_n && o_sda_oe_n)
      else $error("active while not in i2c mode");

endmodule // i2css_slave

/* File: tb/i2css_master.sv */
`timescale 1ns/10ps
module i2css_master (
   // wire levels
   input  wire logic i_scl,
   input  wire logic i_sda,
   // drive, high means released
   output logic      o_scl,
   output logic      o_sda
);
   // ==========================================
   // one bit per 125 ns, scl low between bits
   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   task automatic bitx(input logic b, output logic r);
      o_sda = b;
      #31.25;
      o_scl = 1'b1;
      // slave may hold scl low, the bench timeout covers a hang
      wait (i_scl === 1'b1);
      #31.25;
      r = i_sda;
      #31.25;
      o_scl = 1'b0;
      #31.25;
   endtask

   task automatic start();
      #62.5;
      o_sda = 1'b0;
      #62.5;
      o_scl = 1'b0;
      #31.25;
   endtask

   task automatic stop();
      o_sda = 1'b0;
      #31.25;
      o_scl = 1'b1;
      wait (i_scl === 1'b1);
      #31.25;
      o_sda = 1'b1;
      #62.5;
   endtask

   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(d[i], r);
      end
      bitx(1'b1, ack);
   endtask

   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(nack, r);
   endtask
endmodule // i2css_master

/* File: tb/i2css_slave_test.sv */
`timescale 1ns/10ps
module i2css_slave_test;
   localparam logic [2:0] RC = i2css_pkg::REG_SERIAL_CTRL0;
   localparam logic [2:0] RS = i2css_pkg::REG_STATUS_CTRL;
   localparam logic [2:0] RD = i2css_pkg::REG_DATA;
   localparam logic [2:0] RA = i2css_pkg::REG_OWN_ADDR;
   localparam logic [2:0] RT = i2css_pkg::REG_TIMEOUT;
   logic       i_sys_clk, i_sys_rst, i_wr, i_rd;
   logic [2:0] i_addr;
   logic [7:0] i_wdata, o_rdata, rv, dv;
   logic       o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_irq, o_wake, m_scl, m_sda, ak;
   wire logic  bus_scl, bus_sda;
   int         err_count, n_compared, irqs, wakes, cyc;

   // ==========================================
   // open-drain wires with pull-ups
   assign bus_scl = m_scl & (o_scl_oe_n | o_scl);
   assign bus_sda = m_sda & (o_sda_oe_n | o_sda);

   i2css_slave #(.P_TO_UNIT_CYC(32'h0000000A)) DUT (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(bus_scl), .o_scl(o_scl),
      .o_scl_oe_n(o_scl_oe_n), .i_sda(bus_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
      .o_irq(o_irq), .o_wake(o_wake));
   i2css_master M (.i_scl(bus_scl), .i_sda(bus_sda), .o_scl(m_scl), .o_sda(m_sda));

   always #5 i_sys_clk = ~i_sys_clk;

   always @(posedge i_sys_clk)
   begin
      cyc++;
      if (o_irq === 1'b1) irqs++;
      if (o_wake === 1'b1) wakes++;
      // whole run needs well under a third of this
      if (cyc == 30000)
      begin
         err_count++;
         report_and_stop();
      end
   end

   // ==========================================
   // register port and comparisons
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [2:0] a);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1;
      rv = o_rdata;
   endtask

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("FAIL %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask

   task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
      rd(a);
      chk(n, e, rv & m);
   endtask

   task automatic settle();
      repeat (6) @(posedge i_sys_clk);
      #1;
   endtask

   task report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial
   begin
      i_sys_clk = 1'b0;
      i_sys_rst = 1'b1;
      {i_wr, i_rd, i_addr, i_wdata} = '0;
      {err_count, n_compared, irqs, wakes, cyc} = '0;
      repeat (2) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      rchk(RC, 8'hFF, i2css_pkg::CTRL0_RESET, "ctrl0");
      rchk(RS, 8'hFF, i2css_pkg::STATUS_RESET, "status");
      rchk(RA, 8'hFF, i2css_pkg::OWN_ADDR_RESET, "own_addr");
      rchk(RT, 8'hFF, i2css_pkg::TO_RESET, "timeout");
      wr(3'h7, 8'hFF);
      rchk(3'h7, 8'hFF, 8'h00, "unmapped");
      // only direction, ack and wake bits take a write
      wr(RS, 8'hFF);
      rchk(RS, 8'hFF, 8'h9B, "status_ro");
      wr(RA, 8'h5A);
      M.start();
      M.wbyte(8'h5A, ak);
      M.stop();
      chk("off_ack", 8'h01, {7'h00, ak});
      chk("off_irq", 8'h00, irqs[7:0]);
      wr(RC, 8'hC2);
      wr(RS, 8'h02);
      // own address shifted left one bit must not match
      M.start();
      rchk(RS, 8'h20, 8'h20, "busy");
      M.wbyte(8'hB4, ak);
      chk("miss_ack", 8'h01, {7'h00, ak});
      M.stop();
      rchk(RS, 8'h60, 8'h00, "miss_st");
      chk("miss_irq", 8'h00, irqs[7:0] | wakes[7:0]);
      // receive: ack one byte, refuse the next
      M.start();
      M.wbyte(8'h5A, ak);
      chk("rx_ack", 8'h00, {7'h00, ak});
      settle();
      chk("stretch", 8'h00, {7'h00, o_scl_oe_n});
      rchk(RS, 8'h64, 8'h60, "rx_match");
      chk("rx_irq", 8'h11, {irqs[3:0], wakes[3:0]});
      rd(RD);
      chk("scl_rel", 8'h01, {7'h00, o_scl_oe_n});
      rchk(RS, 8'h80, 8'h00, "moving");
      M.wbyte(8'hA5, ak);
      chk("d1_ack", 8'h00, {7'h00, ak});
      settle();
      rchk(RS, 8'h80, 8'h80, "done");
      wr(RS, 8'h0A);
      rd(RD);
      chk("rx1", 8'hA5, rv);
      M.wbyte(8'h3C, ak);
      chk("d2_ack", 8'h01, {7'h00, ak});
      settle();
      rd(RD);
      chk("rx2", 8'h3C, rv);
      M.stop();
      rchk(RS, 8'h20, 8'h00, "free");
      chk("rx_irqs", 8'h03, irqs[7:0]);
      // transmit: master acks then refuses
      wr(RS, 8'h00);
      M.start();
      M.wbyte(8'h5B, ak);
      settle();
      rchk(RS, 8'h04, 8'h04, "rw");
      wr(RS, 8'h10);
      wr(RD, 8'h96);
      M.rbyte(1'b0, dv);
      chk("tx1", 8'h96, dv);
      settle();
      rchk(RS, 8'h81, 8'h80, "tx_ack");
      wr(RD, 8'h41);
      M.rbyte(1'b1, dv);
      chk("tx2", 8'h41, dv);
      settle();
      rchk(RS, 8'h01, 8'h01, "tx_nack");
      chk("sda_rel", 8'h01, {7'h00, o_sda_oe_n});
      M.stop();
      chk("tx_irqs", 8'h06, irqs[7:0]);
      chk("tx_wake", 8'h01, wakes[7:0]);
      // time-out of three units while the clock is held
      wr(RT, 8'h82);
      M.start();
      M.wbyte(8'h5A, ak);
      repeat (60) @(posedge i_sys_clk);
      rchk(RT, 8'hC0, 8'h40, "to_reg");
      rchk(RS, 8'hFF, i2css_pkg::STATUS_RESET, "to_st");
      chk("to_scl", 8'h01, {7'h00, o_scl_oe_n});
      chk("to_irqs", 8'h08, irqs[7:0]);
      M.stop();
      report_and_stop();
   end
endmodule // i2css_slave_test
